/* rtl/dsm_datapath.sv */
// Scaling shifters, multiplier and indirect-address unit of the DSP core
`timescale 1ns/10ps

// Overview of operation
// - Input shifter moves a 16-bit operand left 0 to 16 into 32 bits.
// - Output shifter moves the accumulator left 0 to 7 toward memory.
// - Storing through the output shifter never changes the accumulator.
// - Product register catches the multiplier; product shifter feeds the arithmetic unit.
// - Product shifter modes: none, left one, left four, right six.
// - Multiplier: signed 16 by 16 giving a full 32-bit signed result.
// - One multiplier operand is always the 16-bit multiplicand register.
// - Each multiplication overwrites the 32-bit product register.
// - One multiplication accepted and finished every clock cycle.
// - Address unit drives the data address for indirect accesses.
// - Eight 16-bit aux registers load from memory or immediate, store back.
// - A 3-bit pointer field in status word zero picks the aux register.
// - Input shift zero-fills low bits; high bits zero or sign per mode.
// - Accumulator is 32 bits; high and low words store separately.
module dsm_datapath
  import dsm_pkg::*;
(
  // Clock and reset
  input  wire logic                            CLK,
  input  wire logic                            SYS_RST,
  // Data and program read buses
  input  wire logic [dsm_pkg::WORD_W-1:0]      DATA_RD,
  input  wire logic [dsm_pkg::WORD_W-1:0]      PROG_IMM,
  // Input shifter control
  input  wire logic                            IN_SRC_IMM,
  input  wire logic [dsm_pkg::IN_SHIFT_W-1:0]  IN_SHIFT,
  input  wire logic                            SIGN_EXTEND_SELECT,
  output logic      [dsm_pkg::DWORD_W-1:0]     ARITH_IN,
  // Product path control
  input  wire dsm_pkg::dsm_psh_e               PSH_MODE,
  output logic      [dsm_pkg::DWORD_W-1:0]     PRODUCT_TO_ARITH,
  // Multiplier control
  input  wire logic                            MCAND_LOAD,
  input  wire logic                            MUL_EN,
  input  wire logic                            MUL_SRC_IMM,
  output logic      [dsm_pkg::WORD_W-1:0]      MULTIPLICAND_REGISTER,
  output logic      [dsm_pkg::DWORD_W-1:0]     PRODUCT_REGISTER,
  // Accumulator from the arithmetic unit
  input  wire logic                            ACC_LOAD,
  input  wire logic [dsm_pkg::DWORD_W-1:0]     ACC_RESULT,
  output logic      [dsm_pkg::DWORD_W-1:0]     ACC,
  // Store path
  input  wire dsm_pkg::dsm_store_e             STORE_SEL,
  input  wire logic [dsm_pkg::OUT_SHIFT_W-1:0] OUT_SHIFT,
  output logic      [dsm_pkg::WORD_W-1:0]      DATA_WR,
  output logic                                 DATA_WR_VALID,
  // Status word zero pointer
  input  wire logic                            STW0_LOAD,
  input  wire logic [dsm_pkg::WORD_W-1:0]      STW0_DATA,
  input  wire logic                            AUX_SEL_LOAD,
  input  wire logic [dsm_pkg::AUX_SEL_W-1:0]   AUX_SEL_NEW,
  output logic      [dsm_pkg::AUX_SEL_W-1:0]   AUX_SELECT_POINTER,
  // Aux register control
  input  wire dsm_pkg::dsm_auxsrc_e            AUX_SRC,
  input  wire logic [dsm_pkg::AUX_SEL_W-1:0]   AUX_LOAD_IDX,
  // Address unit
  input  wire logic                            INDIRECT,
  input  wire dsm_pkg::dsm_aop_e               AUX_OP,
  input  wire logic [dsm_pkg::WORD_W-1:0]      DIRECT_ADDR,
  output logic      [dsm_pkg::WORD_W-1:0]      DATA_ADDR,
  output logic      [dsm_pkg::WORD_W-1:0]      AUX_CURRENT
);

  import dsm_pkg::*;

  // Auxiliary register bank and working registers
  logic [WORD_W-1:0]  indirect_address_regs [AUX_N];
  logic [WORD_W-1:0]  multiplicand_r;
  logic [DWORD_W-1:0] product_r;
  logic [DWORD_W-1:0] acc_r;
  logic [AUX_SEL_W-1:0] aux_sel_r;
  logic [WORD_W-1:0]  data_wr_r;
  logic               data_wr_valid_r;
  logic [WORD_W-1:0]  data_addr_r;

  // Combinational datapath nets
  logic [WORD_W-1:0]  in_word;
  logic [WORD_W-1:0]  mul_operand;
  logic [DWORD_W-1:0] mul_result;
  logic [DWORD_W-1:0] out_scaled;
  logic [WORD_W-1:0]  aux_cur;
  logic [WORD_W-1:0]  aux_step_nxt;
  logic [WORD_W-1:0]  data_wr_nxt;

  // Signed 16x16 full-precision product
  function automatic logic [DWORD_W-1:0] smul(input logic [WORD_W-1:0] a,
                                               input logic [WORD_W-1:0] b);
    smul = DWORD_W'($signed(a) * $signed(b));
  endfunction

  // Post-access update of the selected aux register
  function automatic logic [WORD_W-1:0] aux_step(input logic [WORD_W-1:0] cur,
                                                  input logic [WORD_W-1:0] idx0,
                                                  input dsm_aop_e op);
    case (op)
      DSM_AOP_INC:  aux_step = cur + 16'h0001;
      DSM_AOP_DEC:  aux_step = cur - 16'h0001;
      DSM_AOP_ADD0: aux_step = cur + idx0;
      default:      aux_step = cur;
    endcase
  endfunction

  // Operand selection for input shifter and multiplier
  assign in_word     = IN_SRC_IMM ? PROG_IMM : DATA_RD;
  assign mul_operand = MUL_SRC_IMM ? PROG_IMM : DATA_RD;
  assign mul_result  = smul(multiplicand_r, mul_operand);
  assign aux_cur     = indirect_address_regs[aux_sel_r];
  assign aux_step_nxt = aux_step(aux_cur, indirect_address_regs[0], AUX_OP);

  // The three scaling shifters
  dsm_shift_unit u_shift (
    .in_word            (in_word),
    .in_shift           (IN_SHIFT),
    .sign_extend_select (SIGN_EXTEND_SELECT),
    .in_scaled          (ARITH_IN),
    .acc_value          (acc_r),
    .out_shift          (OUT_SHIFT),
    .out_scaled         (out_scaled),
    .product_value      (product_r),
    .psh_mode           (PSH_MODE),
    .product_scaled     (PRODUCT_TO_ARITH)
  );

  // Multiplicand register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      multiplicand_r <= MULTIPLICAND_RST;
    end else if (MCAND_LOAD) begin
      multiplicand_r <= DATA_RD;
    end
  end

  // Product register: new result each multiply cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      product_r <= PRODUCT_RST;
    end else if (MUL_EN) begin
      product_r <= mul_result;
    end
  end

  // Accumulator, written only by the arithmetic unit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      acc_r <= ACC_RST;
    end else if (ACC_LOAD) begin
      acc_r <= ACC_RESULT;
    end
  end

  // Aux select pointer from status word zero or direct load
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aux_sel_r <= AUX_SEL_RST;
    end else if (STW0_LOAD) begin
      aux_sel_r <= STW0_DATA[STW0_AUX_LSB +: AUX_SEL_W];
    end else if (AUX_SEL_LOAD) begin
      aux_sel_r <= AUX_SEL_NEW;
    end
  end

  // Aux register bank: loads win over post-access update
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < AUX_N; i++) begin
        indirect_address_regs[i] <= AUX_RST;
      end
    end else if (AUX_SRC == DSM_AUX_MEM) begin
      indirect_address_regs[AUX_LOAD_IDX] <= DATA_RD;
    end else if (AUX_SRC == DSM_AUX_IMM) begin
      indirect_address_regs[AUX_LOAD_IDX] <= PROG_IMM;
    end else if (INDIRECT) begin
      indirect_address_regs[aux_sel_r] <= aux_step_nxt;
    end
  end

  // Data address: current aux register when indirect
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_addr_r <= AUX_RST;
    end else begin
      data_addr_r <= INDIRECT ? aux_cur : DIRECT_ADDR;
    end
  end

  // Store word selection
  always_comb begin
    case (STORE_SEL)
      DSM_ST_ACCL: data_wr_nxt = out_scaled[WORD_W-1:0];
      DSM_ST_ACCH: data_wr_nxt = out_scaled[DWORD_W-1:WORD_W];
      DSM_ST_AUX:  data_wr_nxt = indirect_address_regs[AUX_LOAD_IDX];
      default:     data_wr_nxt = 16'h0000;
    endcase
  end

  // Registered write data and valid
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_wr_r       <= 16'h0000;
      data_wr_valid_r <= 1'b0;
    end else begin
      data_wr_r       <= data_wr_nxt;
      data_wr_valid_r <= (STORE_SEL != DSM_ST_NONE);
    end
  end

  // Output drive
  assign MULTIPLICAND_REGISTER = multiplicand_r;
  assign PRODUCT_REGISTER      = product_r;
  assign ACC                   = acc_r;
  assign AUX_SELECT_POINTER    = aux_sel_r;
  assign DATA_WR               = data_wr_r;
  assign DATA_WR_VALID         = data_wr_valid_r;
  assign DATA_ADDR             = data_addr_r;
  assign AUX_CURRENT           = aux_cur;

  // Product register follows multiply one cycle later
  property p_product_capture;
    @(posedge CLK) disable iff (SYS_RST)
      MUL_EN |=> PRODUCT_REGISTER == smul($past(multiplicand_r), $past(mul_operand));
  endproperty
  a_product_capture: assert property (p_product_capture)
    else $error("product register wrong after multiply");

  // Back-to-back multiplies each land
  sequence s_two_mul;
    MUL_EN ##1 MUL_EN;
  endsequence
  property p_mul_throughput;
    @(posedge CLK) disable iff (SYS_RST)
      s_two_mul |=> PRODUCT_REGISTER == $past(mul_result);
  endproperty
  a_mul_throughput: assert property (p_mul_throughput)
    else $error("second multiply did not land");

  // Product holds without multiply
  property p_product_hold;
    @(posedge CLK) disable iff (SYS_RST) !MUL_EN |=> $stable(PRODUCT_REGISTER);
  endproperty
  a_product_hold: assert property (p_product_hold)
    else $error("product changed without multiply");

  // Store never disturbs the accumulator
  property p_store_keeps_acc;
    @(posedge CLK) disable iff (SYS_RST)
      (STORE_SEL != DSM_ST_NONE && !ACC_LOAD) |=> $stable(ACC);
  endproperty
  a_store_keeps_acc: assert property (p_store_keeps_acc)
    else $error("accumulator changed by store");

  // High word store carries shifted accumulator
  property p_store_high;
    @(posedge CLK) disable iff (SYS_RST)
      STORE_SEL == DSM_ST_ACCH |=>
        DATA_WR == 16'(($past(acc_r) << $past(OUT_SHIFT)) >> WORD_W) && DATA_WR_VALID;
  endproperty
  a_store_high: assert property (p_store_high)
    else $error("high word store wrong");

  // Input shift of zero count passes the operand
  property p_in_noshift;
    @(posedge CLK) disable iff (SYS_RST)
      (IN_SHIFT == 5'h00 && !SIGN_EXTEND_SELECT) |-> ARITH_IN == {16'h0000, in_word};
  endproperty
  a_in_noshift: assert property (p_in_noshift)
    else $error("input shifter wrong for zero count");

  // Right-six product mode
  property p_psh_right6;
    @(posedge CLK) disable iff (SYS_RST)
      PSH_MODE == DSM_PSH_RIGHT6 |->
        PRODUCT_TO_ARITH == 32'($signed(product_r) >>> PSH_RIGHT_SIX);
  endproperty
  a_psh_right6: assert property (p_psh_right6)
    else $error("product right shift wrong");

  // Indirect address is current aux register
  property p_indirect_addr;
    @(posedge CLK) disable iff (SYS_RST) INDIRECT |=> DATA_ADDR == $past(aux_cur);
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("indirect address wrong");

  // Memory load of aux register
  property p_aux_load;
    @(posedge CLK) disable iff (SYS_RST)
      AUX_SRC == DSM_AUX_MEM |=> indirect_address_regs[$past(AUX_LOAD_IDX)] == $past(DATA_RD);
  endproperty
  a_aux_load: assert property (p_aux_load)
    else $error("aux register load lost");

  // Pointer taken from status word
  property p_ptr_load;
    @(posedge CLK) disable iff (SYS_RST)
      STW0_LOAD |=> AUX_SELECT_POINTER == $past(STW0_DATA[STW0_AUX_LSB +: AUX_SEL_W]);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("aux pointer not loaded");

  // Full input shift moves the operand into the high word
  property p_in_full_shift;
    @(posedge CLK) disable iff (SYS_RST)
      IN_SHIFT >= IN_SHIFT_MAX |-> ARITH_IN == {in_word, 16'h0000};
  endproperty
  a_in_full_shift: assert property (p_in_full_shift)
    else $error("input shifter wrong for full count");

  // Sign mode copies the operand sign into the high word
  property p_in_sign_fill;
    @(posedge CLK) disable iff (SYS_RST)
      (IN_SHIFT == 5'h00 && SIGN_EXTEND_SELECT) |->
        ARITH_IN == {{WORD_W{in_word[WORD_W-1]}}, in_word};
  endproperty
  a_in_sign_fill: assert property (p_in_sign_fill)
    else $error("input sign extension wrong");

  // Left-four product mode
  property p_psh_left4;
    @(posedge CLK) disable iff (SYS_RST)
      PSH_MODE == DSM_PSH_LEFT4 |-> PRODUCT_TO_ARITH == {product_r[27:0], 4'h0};
  endproperty
  a_psh_left4: assert property (p_psh_left4)
    else $error("product left four shift wrong");

  // Low word store carries shifted accumulator
  property p_store_low;
    @(posedge CLK) disable iff (SYS_RST)
      STORE_SEL == DSM_ST_ACCL |=>
        DATA_WR == 16'($past(acc_r) << $past(OUT_SHIFT)) && DATA_WR_VALID;
  endproperty
  a_store_low: assert property (p_store_low)
    else $error("low word store wrong");

  // Multiplicand holds unless loaded
  property p_mcand_hold;
    @(posedge CLK) disable iff (SYS_RST) !MCAND_LOAD |=> $stable(MULTIPLICAND_REGISTER);
  endproperty
  a_mcand_hold: assert property (p_mcand_hold)
    else $error("multiplicand changed without load");

  // Direct address passes when not indirect
  property p_direct_addr;
    @(posedge CLK) disable iff (SYS_RST) !INDIRECT |=> DATA_ADDR == $past(DIRECT_ADDR);
  endproperty
  a_direct_addr: assert property (p_direct_addr)
    else $error("direct address wrong");

  // Increment step after an indirect access
  sequence s_ind_inc;
    INDIRECT && AUX_OP == DSM_AOP_INC && AUX_SRC == DSM_AUX_HOLD;
  endsequence
  property p_aux_post_inc;
    @(posedge CLK) disable iff (SYS_RST)
      s_ind_inc |=> indirect_address_regs[$past(aux_sel_r)] == $past(aux_cur) + 16'h0001;
  endproperty
  a_aux_post_inc: assert property (p_aux_post_inc)
    else $error("aux register not stepped");

  // Immediate load of aux register
  property p_aux_imm;
    @(posedge CLK) disable iff (SYS_RST)
      AUX_SRC == DSM_AUX_IMM |=> indirect_address_regs[$past(AUX_LOAD_IDX)] == $past(PROG_IMM);
  endproperty
  a_aux_imm: assert property (p_aux_imm)
    else $error("aux immediate load lost");

endmodule

/* rtl/dsm_pkg.sv */
// Package of widths, modes and reset values for the scaling/multiply datapath
package dsm_pkg;

  // Data widths
  localparam int WORD_W    = 16;
  localparam int DWORD_W   = 32;
  localparam int AUX_N     = 8;
  localparam int AUX_SEL_W = 3;

  // Shift count ranges and widths
  localparam int          IN_SHIFT_W   = 5;
  localparam logic [4:0]  IN_SHIFT_MAX = 5'h10;
  localparam int          OUT_SHIFT_W  = 3;

  // Product shifter amounts
  localparam int PSH_LEFT_ONE  = 1;
  localparam int PSH_LEFT_FOUR = 4;
  localparam int PSH_RIGHT_SIX = 6;

  // Status word zero: position of the aux pointer field
  localparam int STW0_AUX_LSB = 13;

  // Reset values
  localparam logic [15:0] MULTIPLICAND_RST = 16'h0000;
  localparam logic [31:0] PRODUCT_RST      = 32'h0000_0000;
  localparam logic [31:0] ACC_RST          = 32'h0000_0000;
  localparam logic [15:0] AUX_RST          = 16'h0000;
  localparam logic [2:0]  AUX_SEL_RST      = 3'h0;

  // Product shift modes
  typedef enum logic [1:0] {
    DSM_PSH_NONE  = 2'h0,
    DSM_PSH_LEFT1 = 2'h1,
    DSM_PSH_LEFT4 = 2'h2,
    DSM_PSH_RIGHT6 = 2'h3
  } dsm_psh_e;

  // Aux register load source
  typedef enum logic [1:0] {
    DSM_AUX_HOLD = 2'h0,
    DSM_AUX_MEM  = 2'h1,
    DSM_AUX_IMM  = 2'h3
  } dsm_auxsrc_e;

  // Address unit step operation
  typedef enum logic [1:0] {
    DSM_AOP_NONE = 2'h0,
    DSM_AOP_INC  = 2'h1,
    DSM_AOP_DEC  = 2'h3,
    DSM_AOP_ADD0 = 2'h2
  } dsm_aop_e;

  // Store word select
  typedef enum logic [1:0] {
    DSM_ST_NONE = 2'h0,
    DSM_ST_ACCL = 2'h1,
    DSM_ST_ACCH = 2'h3,
    DSM_ST_AUX  = 2'h2
  } dsm_store_e;

endpackage

/* rtl/dsm_shift_unit.sv */
// Combinational scaling shifters: input, output and product
`timescale 1ns/10ps
module dsm_shift_unit
  import dsm_pkg::*;
(
  // Input shifter
  input  wire logic [dsm_pkg::WORD_W-1:0]      in_word,
  input  wire logic [dsm_pkg::IN_SHIFT_W-1:0]  in_shift,
  input  wire logic                            sign_extend_select,
  output logic      [dsm_pkg::DWORD_W-1:0]     in_scaled,
  // Output shifter
  input  wire logic [dsm_pkg::DWORD_W-1:0]     acc_value,
  input  wire logic [dsm_pkg::OUT_SHIFT_W-1:0] out_shift,
  output logic      [dsm_pkg::DWORD_W-1:0]     out_scaled,
  // Product shifter
  input  wire logic [dsm_pkg::DWORD_W-1:0]     product_value,
  input  wire dsm_pkg::dsm_psh_e               psh_mode,
  output logic      [dsm_pkg::DWORD_W-1:0]     product_scaled
);

  logic [DWORD_W-1:0] in_ext;
  logic [IN_SHIFT_W-1:0] in_cnt;

  // Extend, clamp count, then shift with zero fill
  always_comb begin
    in_ext = sign_extend_select ? {{WORD_W{in_word[WORD_W-1]}}, in_word}
                                : {{WORD_W{1'b0}}, in_word};
    in_cnt = (in_shift > IN_SHIFT_MAX) ? IN_SHIFT_MAX : in_shift;
    in_scaled = in_ext << in_cnt;
  end

  // Output shifter: shifted copy only
  assign out_scaled = acc_value << out_shift;

  // Product shifter modes
  always_comb begin
    case (psh_mode)
      DSM_PSH_NONE:   product_scaled = product_value;
      DSM_PSH_LEFT1:  product_scaled = product_value << PSH_LEFT_ONE;
      DSM_PSH_LEFT4:  product_scaled = product_value << PSH_LEFT_FOUR;
      DSM_PSH_RIGHT6: product_scaled = $signed(product_value) >>> PSH_RIGHT_SIX;
      default:        product_scaled = product_value;
    endcase
  end

endmodule

/* testbench/dsm_datapath_tb.sv */
// Self-checking bench for the scaling, multiply and address datapath
`timescale 1ns/10ps
module dsm_datapath_tb;
  import dsm_pkg::*;
  // Clock, reset and design signals
  logic        CLK, SYS_RST, IN_SRC_IMM, SIGN_EXTEND_SELECT, MCAND_LOAD, MUL_EN;
  logic        MUL_SRC_IMM, ACC_LOAD, STW0_LOAD, AUX_SEL_LOAD, INDIRECT, DATA_WR_VALID;
  logic [15:0] DATA_RD, PROG_IMM, STW0_DATA, DIRECT_ADDR, MULTIPLICAND_REGISTER;
  logic [15:0] DATA_WR, DATA_ADDR, AUX_CURRENT, mem_addr, mem_data;
  logic [31:0] ACC_RESULT, ARITH_IN, PRODUCT_TO_ARITH, PRODUCT_REGISTER, ACC;
  logic [4:0]  IN_SHIFT;
  logic [2:0]  OUT_SHIFT, AUX_SEL_NEW, AUX_LOAD_IDX, AUX_SELECT_POINTER;
  logic [7:0]  mem_cnt;
  dsm_psh_e    PSH_MODE;
  dsm_store_e  STORE_SEL;
  dsm_auxsrc_e AUX_SRC;
  dsm_aop_e    AUX_OP;
  int          error_cnt = 0;
  int          num_checks = 0;

  // Design and memory model
  dsm_datapath i_dsm_datapath (
    .CLK, .SYS_RST, .DATA_RD, .PROG_IMM, .IN_SRC_IMM, .IN_SHIFT, .SIGN_EXTEND_SELECT,
    .ARITH_IN, .PSH_MODE, .PRODUCT_TO_ARITH, .MCAND_LOAD, .MUL_EN, .MUL_SRC_IMM,
    .MULTIPLICAND_REGISTER, .PRODUCT_REGISTER, .ACC_LOAD, .ACC_RESULT, .ACC, .STORE_SEL,
    .OUT_SHIFT, .DATA_WR, .DATA_WR_VALID, .STW0_LOAD, .STW0_DATA, .AUX_SEL_LOAD,
    .AUX_SEL_NEW, .AUX_SELECT_POINTER, .AUX_SRC, .AUX_LOAD_IDX, .INDIRECT, .AUX_OP,
    .DIRECT_ADDR, .DATA_ADDR, .AUX_CURRENT
  );
  dsm_mem_model i_dsm_mem_model (
    .clk(CLK), .wr_addr(DATA_ADDR), .wr_data(DATA_WR), .wr_valid(DATA_WR_VALID),
    .last_addr(mem_addr), .last_data(mem_data), .wr_cnt(mem_cnt)
  );

  // 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset for six cycles, then registers at their reset values
  task automatic do_reset;
    @(posedge CLK);
    SYS_RST <= 1'b1;
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    #1;
    chk(PRODUCT_REGISTER, PRODUCT_RST);
    chk(ACC, ACC_RST);
    chk(MULTIPLICAND_REGISTER, MULTIPLICAND_RST);
    chk(AUX_SELECT_POINTER, AUX_SEL_RST);
    chk(AUX_CURRENT, AUX_RST);
    chk(DATA_WR_VALID, 1'b0);
  endtask

  // Every input shift, both sources, both extension modes
  task automatic test_in_shift;
    logic [31:0] ext;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s <= 17; s++) begin
        @(posedge CLK);
        SIGN_EXTEND_SELECT <= m[0];
        IN_SRC_IMM <= m[1];
        DATA_RD <= 16'h8E71;
        PROG_IMM <= 16'h5C03;
        IN_SHIFT <= 5'(s);
        #1;
        ext = m[1] ? {16'h0000, PROG_IMM} : {{16{DATA_RD[15] & m[0]}}, DATA_RD};
        chk(ARITH_IN, ext << ((s > 16) ? 16 : s));
      end
    end
  endtask

  // Back-to-back multiplies, then every product shift mode
  task automatic test_multiply;
    logic signed [15:0] mc = 16'sh8003;
    logic signed [15:0] ops [4] = '{16'sh7FFF, 16'sh8000, -16'sh0001, 16'sh1235};
    logic signed [31:0] prod;
    logic        [31:0] e;
    @(posedge CLK);
    DATA_RD <= mc;
    MCAND_LOAD <= 1'b1;
    @(posedge CLK);
    MCAND_LOAD <= 1'b0;
    MUL_EN <= 1'b1;
    for (int i = 0; i <= 4; i++) begin
      MUL_SRC_IMM <= i[0];
      DATA_RD <= i[0] ? 16'h0000 : ops[i % 4];
      PROG_IMM <= i[0] ? ops[i % 4] : 16'h0000;
      if (i == 4) MUL_EN <= 1'b0;
      #1;
      if (i > 0) begin
        prod = mc * ops[i - 1];
        chk(PRODUCT_REGISTER, prod);
        chk(MULTIPLICAND_REGISTER, $unsigned(mc));
      end
      @(posedge CLK);
    end
    for (int m = 0; m < 4; m++) begin
      PSH_MODE <= dsm_psh_e'(m);
      #1;
      case (m)
        0: e = prod;
        1: e = prod <<< PSH_LEFT_ONE;
        2: e = prod <<< PSH_LEFT_FOUR;
        default: e = prod >>> PSH_RIGHT_SIX;
      endcase
      chk(PRODUCT_TO_ARITH, e);
      chk(PRODUCT_REGISTER, prod);
      @(posedge CLK);
    end
  endtask

  // Back-to-back high and low stores at every output shift
  task automatic test_store;
    logic [31:0] sh;
    logic [7:0]  cnt0;
    @(posedge CLK);
    ACC_LOAD <= 1'b1;
    ACC_RESULT <= 32'h8123_4567;
    @(posedge CLK);
    ACC_LOAD <= 1'b0;
    cnt0 = mem_cnt;
    for (int i = 0; i <= 16; i++) begin
      STORE_SEL <= (i == 16) ? DSM_ST_NONE : (i[0] ? DSM_ST_ACCH : DSM_ST_ACCL);
      OUT_SHIFT <= 3'(i >> 1);
      DIRECT_ADDR <= 16'h0200 + 16'(i);
      #1;
      if (i > 0) begin
        sh = 32'h8123_4567 << ((i - 1) >> 1);
        chk(DATA_WR, ((i - 1) % 2) ? sh[31:16] : sh[15:0]);
        chk(DATA_WR_VALID, 1'b1);
        chk(ACC, 32'h8123_4567);
      end
      @(posedge CLK);
    end
    #1;
    chk(DATA_WR_VALID, 1'b0);
    chk(mem_cnt - cnt0, 8'h10);
    chk(mem_addr, 16'h020F);
    chk(mem_data, sh[31:16]);
  endtask

  // Aux loads, pointer selection, aux stores and indirect addressing
  task automatic test_aux;
    dsm_aop_e    ops [5] = '{DSM_AOP_INC, DSM_AOP_INC, DSM_AOP_ADD0, DSM_AOP_DEC, DSM_AOP_NONE};
    logic [15:0] v = 16'h2010;
    @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      AUX_SRC <= i[0] ? DSM_AUX_IMM : DSM_AUX_MEM;
      AUX_LOAD_IDX <= 3'(i);
      DATA_RD <= i[0] ? 16'hDEAD : 16'(i * 16'h1000 + 16'h0010);
      PROG_IMM <= i[0] ? 16'(i * 16'h1000 + 16'h0010) : 16'hBEEF;
      @(posedge CLK);
    end
    for (int p = 0; p < 8; p++) begin
      AUX_SRC <= DSM_AUX_HOLD;
      STW0_LOAD <= p[0];
      STW0_DATA <= {3'(p), 13'h1555};
      AUX_SEL_LOAD <= 1'b1;
      AUX_SEL_NEW <= p[0] ? ~3'(p) : 3'(p);
      STORE_SEL <= DSM_ST_AUX;
      AUX_LOAD_IDX <= 3'(7 - p);
      @(posedge CLK);
      #1;
      chk(AUX_SELECT_POINTER, p);
      chk(AUX_CURRENT, p * 16'h1000 + 16'h0010);
      chk(DATA_WR, (7 - p) * 16'h1000 + 16'h0010);
      @(posedge CLK);
    end
    STW0_LOAD <= 1'b0;
    AUX_SEL_NEW <= 3'h2;
    STORE_SEL <= DSM_ST_NONE;
    @(posedge CLK);
    AUX_SEL_LOAD <= 1'b0;
    INDIRECT <= 1'b1;
    for (int i = 0; i <= 5; i++) begin
      AUX_OP <= (i == 5) ? DSM_AOP_NONE : ops[i];
      DIRECT_ADDR <= 16'h0345;
      if (i == 5) INDIRECT <= 1'b0;
      #1;
      if (i > 0) begin
        chk(DATA_ADDR, v);
        case (ops[i - 1])
          DSM_AOP_INC: v = v + 16'h0001;
          DSM_AOP_DEC: v = v - 16'h0001;
          DSM_AOP_ADD0: v = v + 16'h0010;
          default: v = v;
        endcase
        chk(AUX_CURRENT, v);
      end
      @(posedge CLK);
    end
    #1;
    chk(DATA_ADDR, 16'h0345);
  endtask

  // Main sequence, ending with a second reset
  initial begin
    SYS_RST = 1'b1;
    {IN_SRC_IMM, SIGN_EXTEND_SELECT, MCAND_LOAD, MUL_EN, MUL_SRC_IMM, ACC_LOAD} = '0;
    {STW0_LOAD, AUX_SEL_LOAD, INDIRECT, DATA_RD, PROG_IMM, STW0_DATA, DIRECT_ADDR} = '0;
    {ACC_RESULT, IN_SHIFT, OUT_SHIFT, AUX_SEL_NEW, AUX_LOAD_IDX} = '0;
    PSH_MODE = DSM_PSH_NONE;
    STORE_SEL = DSM_ST_NONE;
    AUX_SRC = DSM_AUX_HOLD;
    AUX_OP = DSM_AOP_NONE;
    do_reset();
    test_in_shift();
    test_multiply();
    test_store();
    test_aux();
    do_reset();
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    error_cnt++;
    results();
  end
endmodule

/* testbench/dsm_mem_model.sv */
// Data memory model recording the stores made by the datapath
`timescale 1ns/10ps
module dsm_mem_model (
  // Clock
  input  wire logic        clk,
  // Store side of the data bus
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_valid,
  // Last store seen and store count
  output logic      [15:0] last_addr,
  output logic      [15:0] last_data,
  output logic      [7:0]  wr_cnt
);
  // Recorded store and count, empty at start
  logic [15:0] addr_r = 16'h0000;
  logic [15:0] data_r = 16'h0000;
  logic [7:0]  cnt_r  = 8'h00;
  // Take one word on each edge where the store is valid
  always @(posedge clk) begin
    if (wr_valid) begin
      addr_r <= wr_addr;
      data_r <= wr_data;
      cnt_r  <= cnt_r + 8'h01;
    end
  end
  // Record outputs
  assign last_addr = addr_r;
  assign last_data = data_r;
  assign wr_cnt    = cnt_r;
endmodule
